/* File: loader_rt_status.sv */
// Summary of operation
// - One status word per message not ended by a receive error; after received data, before transmitted data.
// - Status word starts 2 to 5 us after last command or data word.
// - Bits 15..11 carry the software assigned terminal address.
// - Undefined subaddress and direction may set message error bit 10.
// - Short, invalid, mistimed or gapped receive data flags error on next status.
// - Message error shows in one status word, then clears unless repeated.
// - Service request bit 8 set only when answering the Activity Message.
// - Service request equals nonzero request bits 10..0 in Activity answer when not busy.
// - Busy bit 3 may be set; it suppresses the message's data words.
// - Loader sustains at least 2K load or verify data words per second.
// - Terminal flag bit 0 set whenever error, request or busy is set.
// - Bits 9, 7, 6, 5, 4, 2 and 1 always zero.
// - Activity Message is transmit, subaddress 07h, one word; data unless busy.
// - Busy and service request never set together.
// - Activity word: direction bit 10, subaddress 9..5, count 4..0, 15..11 zero.
module loader_rt_status
   import loader_rt_pkg::*;
#(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Decoded bus words from the receiver
   input  wire loader_rt_pkg::rx_word_t rx,
   // Words to the bus encoder
   output loader_rt_pkg::tx_word_t   tx,
   input  wire logic                 tx_ready,
   // AXI4-Lite write channels
   input  wire logic [AW-1:0]        awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   // AXI4-Lite read channels
   input  wire logic [AW-1:0]        araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready
);

   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (AW < 8) begin : g_aw_check
      $error("AW must be at least 8");
   end

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      rt_state_t          st;
      logic [15:0]        cmd;
      logic [5:0]         left;
      logic [4:0]         idx;
      logic [TIMER_W-1:0] timer;
      logic               me_pend;
      logic               me_now;
      logic [15:0]        last_status;
      tx_word_t           tx;
      logic [4:0]         ta;
      logic               busy;
      logic               supp;
      logic [REQ_W-1:0]   req;
      logic [31:0]        rx_en;
      logic [31:0]        tx_en;
      logic [15:0]        msg_cnt;
      logic [15:0]        err_cnt;
      logic [15:0]        rx_last;
      logic [4:0]         rx_idx;
   } core_t;

   core_t       r;
   core_t       n;
   logic [15:0] txbuf [32];

   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [31:0]   wr_data;
   logic [3:0]    wr_strb;
   logic          wr_err;
   logic [AW-1:0] rd_addr;
   logic [31:0]   rd_data;
   logic          rd_err;

   logic          cmd_hit;
   logic          take_cmd;
   logic          err_event;
   logic          cmd_tr;
   logic [4:0]    cmd_sa;
   logic [4:0]    cmd_wc;
   logic          is_act;
   logic          sr_bit;
   logic          me_bit;
   logic [15:0]   status_w;
   logic [15:0]   act_word;
   logic [15:0]   data_w;
   logic [31:0]   wmask;
   logic          wr_txbuf;

   // ==========================================================
   // Register bus slave
   // ==========================================================
   axil_port #(
      .AW (AW)
   ) u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   // Byte lane mask from write strobes
   assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_txbuf = wr_addr[TXBUF_BIT];

   // Write decode; upper address bits must be clear
   always_comb begin
      wr_err = 1'b0;
      if ((wr_addr >> 8) != '0) begin
         wr_err = 1'b1;
      end else if (!wr_txbuf) begin
         unique case (wr_addr[7:0])
            REG_CTRL, REG_REQUEST, REG_RX_SA_EN, REG_TX_SA_EN: wr_err = 1'b0;
            default: wr_err = 1'b1;
         endcase
      end
   end

   // Read decode; status and counters show live state
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if ((rd_addr >> 8) != '0) begin
         rd_err = 1'b1;
      end else if (rd_addr[TXBUF_BIT]) begin
         rd_data = {16'h0000, txbuf[rd_addr[6:2]]};
      end else begin
         unique case (rd_addr[7:0])
            REG_CTRL: begin
               rd_data[CTRL_TA_LSB +: 5] = r.ta;
               rd_data[CTRL_BSY_BIT]     = r.busy;
               rd_data[CTRL_SUP_BIT]     = r.supp;
            end
            REG_REQUEST:  rd_data = {21'h000000, r.req};
            REG_RX_SA_EN: rd_data = r.rx_en;
            REG_TX_SA_EN: rd_data = r.tx_en;
            REG_STATUS:   rd_data = {12'h000, r.st, r.me_pend, r.last_status};
            REG_COUNTS:   rd_data = {r.err_cnt, r.msg_cnt};
            REG_RX_LAST:  rd_data = {11'h000, r.rx_idx, r.rx_last};
            default:      rd_err = 1'b1;
         endcase
      end
   end

   // Transmit data buffer, low two byte lanes
   always_ff @(posedge aclk) begin
      if (wr_en && !wr_err && wr_txbuf) begin
         if (wr_strb[0]) begin
            txbuf[wr_addr[6:2]][7:0] <= wr_data[7:0];
         end
         if (wr_strb[1]) begin
            txbuf[wr_addr[6:2]][15:8] <= wr_data[15:8];
         end
      end
   end

   // ==========================================================
   // Command fields and status word
   // ==========================================================
   assign cmd_tr  = r.cmd[CW_TR_BIT];
   assign cmd_sa  = r.cmd[CW_SA_LSB +: 5];
   assign cmd_wc  = r.cmd[CW_WC_LSB +: 5];
   assign is_act  = cmd_tr && cmd_sa == ACT_SA && cmd_wc == ACT_WC;
   assign cmd_hit = rx.valid && rx.is_cmd && !rx.bad
                    && rx.word[SW_TA_LSB +: 5] == r.ta;

   // Busy wins over the request bits
   assign sr_bit = is_act && r.req != '0 && !r.busy;
   assign me_bit = r.me_now | r.me_pend;

   // Status word build; unlisted bits stay zero
   always_comb begin
      status_w                      = 16'h0000;
      status_w[SW_TA_LSB +: 5]      = r.ta;
      status_w[SW_ME_BIT]           = me_bit;
      status_w[SW_SR_BIT]           = sr_bit;
      status_w[SW_BSY_BIT]          = r.busy;
      status_w[SW_TF_BIT]           = me_bit | sr_bit | r.busy;
   end

   // Activity data word: top five bits zero
   assign act_word = {5'h00, r.req};
   assign data_w   = is_act ? act_word : txbuf[r.idx];

   // ==========================================================
   // Message sequencer
   // ==========================================================
   always_comb begin
      n         = r;
      take_cmd  = 1'b0;
      err_event = 1'b0;
      unique case (r.st)
         ST_IDLE: begin
            take_cmd = cmd_hit;
         end
         ST_RECV: begin
            if (rx.valid && rx.is_cmd) begin
               // Command before all data: short message
               err_event = 1'b1;
               take_cmd  = cmd_hit;
               n.st      = ST_IDLE;
            end else if (rx.valid && rx.bad) begin
               // Invalid word or bad sync: no answer now
               err_event = 1'b1;
               n.st      = ST_IDLE;
            end else if (rx.valid) begin
               n.rx_last = rx.word;
               n.rx_idx  = r.idx;
               n.idx     = r.idx + 5'd1;
               n.left    = r.left - 6'd1;
               n.timer   = TIMER_W'(DATA_GAP_CYC);
               if (r.left == 6'd1) begin
                  // Status follows the received data
                  n.st    = ST_GAP;
                  n.timer = TIMER_W'(RESP_CYC);
               end
            end else if (r.timer == '0) begin
               // Data stopped flowing: not contiguous
               err_event = 1'b1;
               n.st      = ST_IDLE;
            end else begin
               n.timer = r.timer - TIMER_W'(1);
            end
         end
         ST_GAP: begin
            take_cmd = cmd_hit;
            if (r.timer <= TIMER_W'(1)) begin
               // Response gap elapsed
               n.st = ST_SEND_STATUS;
               n.tx = '{valid: 1'b1, is_status: 1'b1, word: status_w};
            end else begin
               n.timer = r.timer - TIMER_W'(1);
            end
         end
         ST_SEND_STATUS: begin
            take_cmd = cmd_hit;
            if (tx_ready) begin
               n.last_status = r.tx.word;
               n.me_now      = 1'b0;
               n.msg_cnt     = r.msg_cnt + 16'd1;
               if (cmd_tr && !r.tx.word[SW_BSY_BIT] && !(r.me_now && r.supp)) begin
                  // Status precedes transmitted data
                  n.st   = ST_SEND_DATA;
                  n.tx   = '{valid: 1'b1, is_status: 1'b0, word: data_w};
                  n.left = (cmd_wc == 5'd0) ? 6'd32 : {1'b0, cmd_wc};
                  n.idx  = r.idx + 5'd1;
               end else begin
                  // Receive done, busy, or this command's error (me_now) with suppress set: no data words
                  n.st = ST_IDLE;
                  n.tx = '0;
               end
            end
         end
         ST_SEND_DATA: begin
            take_cmd = cmd_hit;
            if (tx_ready) begin
               n.left = r.left - 6'd1;
               if (r.left == 6'd1) begin
                  n.st = ST_IDLE;
                  n.tx = '0;
               end else begin
                  n.tx.word = data_w;
                  n.idx     = r.idx + 5'd1;
               end
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // A new valid command supersedes any message in progress
      if (take_cmd) begin
         n.cmd    = rx.word;
         n.idx    = 5'd0;
         n.tx     = '0;
         // Undefined subaddress and direction flags this answer
         if (rx.word[CW_TR_BIT]) begin
            if (rx.word[CW_SA_LSB +: 5] == ACT_SA) begin
               n.me_now = rx.word[CW_WC_LSB +: 5] != ACT_WC;
            end else begin
               n.me_now = !r.tx_en[rx.word[CW_SA_LSB +: 5]];
            end
            n.st    = ST_GAP;
            n.timer = TIMER_W'(RESP_CYC);
         end else begin
            n.me_now = !r.rx_en[rx.word[CW_SA_LSB +: 5]];
            n.st     = ST_RECV;
            n.left   = (rx.word[CW_WC_LSB +: 5] == 5'd0) ? 6'd32
                                                         : {1'b0, rx.word[CW_WC_LSB +: 5]};
            n.timer  = TIMER_W'(DATA_GAP_CYC);
         end
         // Granted request is retired
         if (r.req != '0 && rx.word[REQ_W-1:0] == r.req) begin
            n.req = '0;
         end
      end

      // Pending error shown once, a new error wins over the clear
      if (r.st == ST_SEND_STATUS && tx_ready) begin
         n.me_pend = err_event;
      end else begin
         n.me_pend = r.me_pend | err_event;
      end
      if (err_event) begin
         n.err_cnt = r.err_cnt + 16'd1;
      end

      // Software register writes
      if (wr_en && !wr_err && !wr_txbuf) begin
         unique case (wr_addr[7:0])
            REG_CTRL: begin
               if (wr_strb[0]) begin
                  n.ta = wr_data[CTRL_TA_LSB +: 5];
               end
               if (wr_strb[1]) begin
                  n.busy = wr_data[CTRL_BSY_BIT];
                  n.supp = wr_data[CTRL_SUP_BIT];
               end
            end
            REG_REQUEST: begin
               n.req = ((r.req & ~wmask[REQ_W-1:0]) | (wr_data[REQ_W-1:0] & wmask[REQ_W-1:0]));
            end
            REG_RX_SA_EN: begin
               n.rx_en = (r.rx_en & ~wmask) | (wr_data & wmask);
            end
            REG_TX_SA_EN: begin
               n.tx_en = (r.tx_en & ~wmask) | (wr_data & wmask);
            end
            default: begin
               n.req = n.req;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r       <= '0;
         r.st    <= ST_IDLE;
         r.ta    <= TA_RST;
         r.rx_en <= SA_EN_RST;
         r.tx_en <= SA_EN_RST;
      end else begin
         r <= n;
      end
   end

   assign tx = r.tx;

endmodule

/* File: loader_rt_pkg.sv */
package loader_rt_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS       = 10;
   localparam int RESP_MIN_NS  = 2000;
   localparam int RESP_MAX_NS  = 5000;
   // Least time, so round up
   localparam int RESP_CYC     = (RESP_MIN_NS + CLK_NS - 1) / CLK_NS;
   // Word time plus gap allowance; a longest time, so round down
   localparam int DATA_GAP_NS  = 24000;
   localparam int DATA_GAP_CYC = DATA_GAP_NS / CLK_NS;
   localparam int TIMER_W      = 12;

   // ==========================================================
   // Status and command word fields
   // ==========================================================
   localparam int SW_TA_LSB   = 11;
   localparam int SW_ME_BIT   = 10;
   localparam int SW_SR_BIT   = 8;
   localparam int SW_BSY_BIT  = 3;
   localparam int SW_TF_BIT   = 0;
   localparam int CW_TR_BIT   = 10;
   localparam int CW_SA_LSB   = 5;
   localparam int CW_WC_LSB   = 0;
   localparam int REQ_W       = 11;
   localparam logic [4:0] ACT_SA = 5'h07;
   localparam logic [4:0] ACT_WC = 5'h01;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_REQUEST  = 8'h04;
   localparam logic [7:0] REG_RX_SA_EN = 8'h08;
   localparam logic [7:0] REG_TX_SA_EN = 8'h0C;
   localparam logic [7:0] REG_STATUS   = 8'h10;
   localparam logic [7:0] REG_COUNTS   = 8'h14;
   localparam logic [7:0] REG_RX_LAST  = 8'h18;
   localparam int         TXBUF_BIT    = 7;
   localparam int         CTRL_TA_LSB  = 0;
   localparam int         CTRL_BSY_BIT = 8;
   localparam int         CTRL_SUP_BIT = 9;
   localparam logic [4:0]  TA_RST      = 5'h00;
   localparam logic [31:0] SA_EN_RST   = 32'h0000_0000;

   // ==========================================================
   // Bus answers
   // ==========================================================
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic        valid;
      logic        is_cmd;
      logic        bad;
      logic [15:0] word;
   } rx_word_t;

   typedef struct packed {
      logic        valid;
      logic        is_status;
      logic [15:0] word;
   } tx_word_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RECV,
      ST_GAP,
      ST_SEND_STATUS,
      ST_SEND_DATA
   } rt_state_t;

endpackage

/* File: axil_port.sv */
module axil_port
   import loader_rt_pkg::*;
#(
   parameter int AW = 8
) (
   // Clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // Write address and data
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   // Write response
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   // Read address and data
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   // Register file side
   output logic               wr_en,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_strb,
   input  wire logic          wr_err,
   output logic [AW-1:0]      rd_addr,
   input  wire logic [31:0]   rd_data,
   input  wire logic          rd_err
);

   typedef struct packed {
      logic          awready;
      logic          aw_full;
      logic [AW-1:0] awaddr;
      logic          wready;
      logic          w_full;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          ar_full;
      logic [AW-1:0] araddr;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } port_t;

   port_t r;
   port_t n;
   logic  do_wr;

   // Write fires once both halves are held
   assign do_wr   = r.aw_full & r.w_full & ~r.bvalid;
   assign wr_en   = do_wr;
   assign wr_addr = r.awaddr;
   assign wr_data = r.wdata;
   assign wr_strb = r.wstrb;
   assign rd_addr = r.araddr;

   // Handshake sequencing
   always_comb begin
      n = r;
      if (awvalid && r.awready) begin
         n.awready = 1'b0;
         n.aw_full = 1'b1;
         n.awaddr  = awaddr;
      end
      if (wvalid && r.wready) begin
         n.wready = 1'b0;
         n.w_full = 1'b1;
         n.wdata  = wdata;
         n.wstrb  = wstrb;
      end
      if (do_wr) begin
         n.aw_full = 1'b0;
         n.w_full  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (r.bvalid && bready) begin
         n.bvalid  = 1'b0;
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end
      if (arvalid && r.arready) begin
         n.arready = 1'b0;
         n.ar_full = 1'b1;
         n.araddr  = araddr;
      end
      if (r.ar_full && !r.rvalid) begin
         n.ar_full = 1'b0;
         n.rvalid  = 1'b1;
         n.rdata   = rd_err ? 32'h0000_0000 : rd_data;
         n.rresp   = rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (r.rvalid && rready) begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r         <= '0;
         r.awready <= 1'b1;
         r.wready  <= 1'b1;
         r.arready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign awready = r.awready;
   assign wready  = r.wready;
   assign bvalid  = r.bvalid;
   assign bresp   = r.bresp;
   assign arready = r.arready;
   assign rvalid  = r.rvalid;
   assign rdata   = r.rdata;
   assign rresp   = r.rresp;

endmodule

/* File: loader_rt_status_asserts.sv */
module loader_rt_status_asserts
   import loader_rt_pkg::*;
(
   // Clock and reset
   input wire logic                    aclk,
   input wire logic                    aresetn,
   // Bus link
   input wire loader_rt_pkg::rx_word_t rx,
   input wire loader_rt_pkg::tx_word_t tx,
   input wire logic                    tx_ready
);
   logic [9:0] gap_reg;
   logic       st;
   logic       hs;
   // Status offered and status taken
   assign st = tx.valid && tx.is_status;
   assign hs = st && tx_ready;
   // Cycles since the last received word, saturating
   always_ff @(posedge aclk) begin
      gap_reg <= (rx.valid || !aresetn) ? 10'h000 : gap_reg + {9'h000, ~&gap_reg};
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ========
   // Checks
   property p_zero; st |-> (tx.word & 16'h02F6) == 16'h0000; endproperty
   a_zero: assert property (p_zero) else $error("spare status bit set");
   property p_tf; st |-> tx.word[0] == (tx.word[10] | tx.word[8] | tx.word[3]); endproperty
   a_tf: assert property (p_tf) else $error("terminal flag wrong");
   property p_excl; st |-> !(tx.word[8] && tx.word[3]); endproperty
   a_excl: assert property (p_excl) else $error("busy with request");
   property p_hold; tx.valid && !tx_ready |=> tx.valid && $stable(tx.word); endproperty
   a_hold: assert property (p_hold) else $error("word dropped");
   property p_busy; hs && tx.word[3] |=> !(tx.valid && !tx.is_status); endproperty
   a_busy: assert property (p_busy) else $error("data after busy");
   property p_sr;
      hs && tx.word[8] |=> tx.valid && !tx.is_status && tx.word[10:0] != 11'h000
         && tx.word[15:11] == 5'h00;
   endproperty
   a_sr: assert property (p_sr) else $error("request word wrong");
   property p_gap; $rose(st) |-> gap_reg >= 10'h0C7 && gap_reg <= 10'h1F4; endproperty
   a_gap: assert property (p_gap) else $error("response time");
   property p_one; hs && tx.word[8] ##1 (tx.valid && tx_ready) |=> !tx.valid; endproperty
   a_one: assert property (p_one) else $error("extra data word");
   c_sr: cover property (hs && tx.word[8]);
   c_bsy: cover property (hs && tx.word[3]);
   c_me: cover property (hs && tx.word[10]);
endmodule

bind loader_rt_status loader_rt_status_asserts CHK (.aclk(aclk), .aresetn(aresetn),
   .rx(rx), .tx(tx), .tx_ready(tx_ready));

/* File: bus_ctrl_model.sv */
module bus_ctrl_model
   import loader_rt_pkg::*;
(
   // Clock
   input wire logic                    aclk,
   // Bus link
   output loader_rt_pkg::rx_word_t     rx,
   input wire loader_rt_pkg::tx_word_t tx,
   output logic                        tx_ready,
   input wire logic                    slow
);
   logic [16:0] got[$];
   initial begin
      rx = '0;
      tx_ready = 1'b0;
   end
   // Encoder side, prompt or stalling
   always @(posedge aclk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx.valid && tx_ready)
         got.push_back({tx.is_status, tx.word});
   end
   // One word, then the line idles inverted
   task automatic send(input logic [15:0] w, input logic c = 1'b1, input logic b = 1'b0);
      rx <= '{1'b1, c, b, w};
      @(posedge aclk);
      rx <= '{1'b0, 1'b0, 1'b0, ~w};
      repeat (40) @(posedge aclk);
   endtask
endmodule

/* File: test_loader_rt_status.sv */
module test_loader_rt_status;
   timeunit 1ns;
   timeprecision 100ps;
   import loader_rt_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, seed = 32'hC618072E;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tx_ready;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb = 4'hF;
   rx_word_t    rx;
   tx_word_t    tx;
   int          n_fail = 0, comparisons = 0;
   logic [16:0] exp[$];
   logic [4:0]  ta;
   logic [10:0] req;
   logic [15:0] d0, d1;
   loader_rt_status DUT (.*);
   bus_ctrl_model P (.aclk(aclk), .rx(rx), .tx(tx), .tx_ready(tx_ready), .slow(slow));
   always #5 aclk = ~aclk;
   // ========
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [16:0] sw(input logic me, sr, bsy);
      return {1'b1, ta, me, 1'b0, sr, 4'h0, bsy, 2'h0, me | sr | bsy};
   endfunction
   function automatic logic [15:0] cw(input logic tr, input logic [4:0] sa, wc);
      return {ta, tr, sa, wc};
   endfunction
   task automatic conclude();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, e, input string m);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic tmo(input int i);
      if (i >= 1000) begin
         cmp(32'h1, 32'h0, "timeout");
         conclude();
      end
   endtask
   // Register bus master
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 1000 && !(bvalid && bready); i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      tmo(i);
      cmp(32'(bresp), 32'(RESP_OKAY), "bresp");
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int i;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 1000 && !(rvalid && rready); i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end
      tmo(i);
      cmp(rdata, e, "rdata");
      cmp(32'(rresp), 32'(r), "rresp");
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Expected words against what the controller took
   task automatic chk(input int n, input logic [16:0] s = 17'h0,
                      input logic [15:0] x = 16'h0, y = 16'h0);
      int i;
      if (n > 0) exp.push_back(s);
      if (n > 1) exp.push_back({1'b0, x});
      if (n > 2) exp.push_back({1'b0, y});
      for (i = 0; i < 1000 && P.got.size() < n; i++) @(posedge aclk);
      tmo(i);
      repeat (300) @(posedge aclk);
      cmp(32'(P.got.size()), 32'(n), "word count");
      while (exp.size() > 0 && P.got.size() > 0)
         cmp(32'(P.got.pop_front()), 32'(exp.pop_front()), "bus word");
      P.got.delete();
      exp.delete();
   endtask
   // ========
   // Sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      ta = 5'(rnd() % 31);
      req = {1'b0, 5'h04, 5'(rnd()) | 5'h01};
      d0 = 16'(rnd());
      d1 = 16'(rnd());
      axr(REG_CTRL, 32'h0, RESP_OKAY);
      axr(8'h40, 32'h0, RESP_SLVERR);
      axw(REG_CTRL, 32'(ta));
      axw(REG_RX_SA_EN, 32'hFFFFFFFF);
      axw(REG_TX_SA_EN, 32'hFFFFFFFF);
      axw(REG_REQUEST, 32'(req));
      axw(8'h80, 32'(d0));
      axw(8'h84, 32'(d1));
      P.send(cw(1'b1, ACT_SA, ACT_WC));
      chk(2, sw(1'b0, 1'b1, 1'b0), 16'(req));
      axw(REG_CTRL, 32'(ta) | 32'h100);
      P.send(cw(1'b1, ACT_SA, ACT_WC));
      chk(1, sw(1'b0, 1'b0, 1'b1));
      axw(REG_CTRL, 32'(ta));
      P.send(cw(1'b1, ACT_SA, ACT_WC));
      chk(2, sw(1'b0, 1'b1, 1'b0), 16'(req));
      P.send({ta, req});
      repeat (req[4:0]) P.send(d0, 1'b0);
      chk(1, sw(1'b0, 1'b0, 1'b0));
      axr(REG_REQUEST, 32'h0, RESP_OKAY);
      slow <= 1'b1;
      P.send(cw(1'b1, 5'h03, 5'h02));
      chk(3, sw(1'b0, 1'b0, 1'b0), d0, d1);
      axw(REG_TX_SA_EN, 32'h0);
      P.send(cw(1'b1, 5'h03, 5'h01));
      chk(2, sw(1'b1, 1'b0, 1'b0), d0);
      slow <= 1'b0;
      P.send(cw(1'b0, 5'h04, 5'h02));
      P.send(d0, 1'b0);
      P.send(d1, 1'b0, 1'b1);
      chk(0);
      P.send(cw(1'b1, ACT_SA, ACT_WC));
      chk(2, sw(1'b1, 1'b0, 1'b0));
      P.send(cw(1'b0, 5'h04, 5'h02));
      P.send(d0, 1'b0);
      P.send(d1, 1'b0);
      chk(1, sw(1'b0, 1'b0, 1'b0));
      conclude();
   end
endmodule
